// >>> rtl/buzzer_frequency_output.sv
// Buzzer tone generator with AXI4-Lite registers and shared port A pins
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps

// Functional notes
// - In pair mode, line seven drives the inverse of line six tone while line six is an output, else its own data bit.
// - Pin function 00 all I/O, 01 tone on six, 11 pair, 10 reserved.
// - Frequency code 000..111 divides time base clock by 2^2..2^9.
// - Divider advances on time base ticks, only while time base enable set.
// - Time base comes from slow oscillator or system clock divided by 4.
// - Pair mode with line six output: line six data high enables both outputs, low holds both low.
// - Pair mode: line seven data bit does not affect inverted tone pin.
// - Single mode: line six data gates tone; line seven stays ordinary I/O.
// - A line set as input stays input whatever pin function is chosen.
// - Upper three bits of buzzer control read as zero.
// - Time base enable is bit 7 of time base control; 1 enables.
module buzzer_frequency_output (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        LOW_SPEED_INTERNAL_OSC,
    input  wire logic [7:0]  PORT_A_IN,
    output logic      [7:0]  PORT_A_OUT,
    output logic      [7:0]  PORT_A_OE_N,
    output logic      [7:0]  PORT_A_PIN_STATE,
    input  wire logic [3:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic      [1:0]  S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [3:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic      [31:0] S_AXI_RDATA,
    output logic      [1:0]  S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    function automatic logic mapped(input logic [3:0] a);
        if (a == tone_pkg::ADDR_BUZZER_CONTROL) begin
            return 1'b1;
        end else if (a == tone_pkg::ADDR_TIME_BASE_CTRL) begin
            return 1'b1;
        end else if (a == tone_pkg::ADDR_PORT_A_DIR) begin
            return 1'b1;
        end else if (a == tone_pkg::ADDR_PORT_A_DATA) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    logic [7:0]  buzzer_control_reg;
    logic [7:0]  time_base_reg;
    logic [7:0]  port_a_direction_reg;
    logic [7:0]  port_a_output_data_reg;
    logic [3:0]  awaddr_reg;
    logic        aw_held_reg;
    logic        awready_reg;
    logic [7:0]  wdata_reg;
    logic        wstrb0_reg;
    logic        w_held_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [2:0]  osc_sync_reg;
    logic [7:0]  pin_sync1_reg;
    logic [7:0]  pin_sync2_reg;
    logic [7:0]  pin_sync3_reg;
    logic [7:0]  pin_state_reg;
    logic [1:0]  sys_div_reg;
    logic        tb_tick;
    logic [8:0]  divider_reg;
    logic        tone_reg;
    logic [3:0]  power;
    logic        half_period_done;
    logic [1:0]  pin_function_select;
    logic [2:0]  tone_divider_select;
    logic        time_base_enable;
    logic        dir_line_six;
    logic        dir_line_seven;
    logic        do_write;
    tone_pkg::pin_drive_t drive_next;
    tone_pkg::pin_drive_t drive_reg;

    assign pin_function_select = buzzer_control_reg[tone_pkg::FUNC_MSB:tone_pkg::FUNC_LSB];
    assign tone_divider_select = buzzer_control_reg[tone_pkg::FREQ_MSB:tone_pkg::FREQ_LSB];
    assign time_base_enable    = time_base_reg[tone_pkg::TB_ENABLE_BIT];
    assign dir_line_six        = port_a_direction_reg[tone_pkg::LINE_SIX];
    assign dir_line_seven      = port_a_direction_reg[tone_pkg::LINE_SEVEN];

    // AXI4-Lite write channel: address and data taken in either order
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            awaddr_reg  <= 4'h0;
        end else if (S_AXI_AWVALID && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            awaddr_reg  <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
            wdata_reg  <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (S_AXI_WVALID && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg  <= S_AXI_WDATA[7:0];
            wstrb0_reg <= S_AXI_WSTRB[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= tone_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= mapped(awaddr_reg) ? tone_pkg::RESP_OKAY : tone_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            buzzer_control_reg     <= tone_pkg::BUZZER_CONTROL_RESET;
            time_base_reg          <= tone_pkg::TIME_BASE_RESET;
            port_a_direction_reg   <= tone_pkg::PORT_DIR_RESET;
            port_a_output_data_reg <= tone_pkg::PORT_DATA_RESET;
        end else if (do_write && wstrb0_reg) begin
            if (awaddr_reg == tone_pkg::ADDR_BUZZER_CONTROL) begin
                buzzer_control_reg <= wdata_reg & tone_pkg::BUZZER_CONTROL_MASK;
            end else if (awaddr_reg == tone_pkg::ADDR_TIME_BASE_CTRL) begin
                time_base_reg <= wdata_reg & tone_pkg::TIME_BASE_MASK;
            end else if (awaddr_reg == tone_pkg::ADDR_PORT_A_DIR) begin
                port_a_direction_reg <= wdata_reg;
            end else if (awaddr_reg == tone_pkg::ADDR_PORT_A_DATA) begin
                port_a_output_data_reg <= wdata_reg;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge CLK) begin
        if (RST) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= tone_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && arready_reg) begin
            // Address is taken first; read data follows on the next cycle
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= tone_pkg::RESP_OKAY;
            if (S_AXI_ARADDR == tone_pkg::ADDR_BUZZER_CONTROL) begin
                rdata_reg <= {24'h0, buzzer_control_reg};
            end else if (S_AXI_ARADDR == tone_pkg::ADDR_TIME_BASE_CTRL) begin
                rdata_reg <= {24'h0, time_base_reg};
            end else if (S_AXI_ARADDR == tone_pkg::ADDR_PORT_A_DIR) begin
                rdata_reg <= {24'h0, port_a_direction_reg};
            end else if (S_AXI_ARADDR == tone_pkg::ADDR_PORT_A_DATA) begin
                rdata_reg <= {24'h0, pin_state_reg};
            end else begin
                rdata_reg <= 32'h0;
                rresp_reg <= tone_pkg::RESP_SLVERR;
            end
        end else if (rvalid_reg && S_AXI_RREADY) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // Slow oscillator and pin inputs through three flops
    always_ff @(posedge CLK) begin
        if (RST) begin
            osc_sync_reg  <= 3'h0;
            pin_sync1_reg <= 8'h00;
            pin_sync2_reg <= 8'h00;
            pin_sync3_reg <= 8'h00;
            pin_state_reg <= 8'h00;
        end else begin
            osc_sync_reg  <= {osc_sync_reg[1:0], LOW_SPEED_INTERNAL_OSC};
            pin_sync1_reg <= PORT_A_IN;
            pin_sync2_reg <= pin_sync1_reg;
            pin_sync3_reg <= pin_sync2_reg;
            for (int i = 0; i < 8; i++) begin
                if (pin_sync2_reg[i] == pin_sync3_reg[i]) begin
                    pin_state_reg[i] <= pin_sync3_reg[i];
                end
            end
        end
    end

    // Time base tick source
    always_ff @(posedge CLK) begin
        if (RST) begin
            sys_div_reg <= 2'h0;
        end else begin
            sys_div_reg <= sys_div_reg + 2'h1;
        end
    end

    always_comb begin
        if (time_base_reg[tone_pkg::TB_SOURCE_BIT]) begin
            tb_tick = (sys_div_reg == tone_pkg::SYS_DIVIDE_MAX);
        end else begin
            tb_tick = osc_sync_reg[1] && !osc_sync_reg[2];
        end
    end

    // Tone divider: half period of 2^(code+1) time base ticks
    assign power = {1'b0, tone_divider_select} + tone_pkg::MIN_POWER - 4'h1;
    assign half_period_done = (divider_reg == 9'((10'h1 << power) - 10'h1));

    always_ff @(posedge CLK) begin
        if (RST) begin
            divider_reg <= 9'h0;
            tone_reg    <= 1'b0;
        end else if (!time_base_enable) begin
            divider_reg <= 9'h0;
            tone_reg    <= 1'b0;
        end else if (tb_tick) begin
            if (half_period_done || divider_reg > 9'((10'h1 << power) - 10'h1)) begin
                divider_reg <= 9'h0;
                tone_reg    <= !tone_reg;
            end else begin
                divider_reg <= divider_reg + 9'h1;
            end
        end
    end

    // Pin drive: output enable low while driving
    always_comb begin
        drive_next.out  = port_a_output_data_reg;
        drive_next.oe_n = port_a_direction_reg;
        case (pin_function_select)
            tone_pkg::FUNC_SINGLE: begin
                drive_next.out[tone_pkg::LINE_SIX] =
                    tone_reg && port_a_output_data_reg[tone_pkg::LINE_SIX];
            end
            tone_pkg::FUNC_PAIR: begin
                drive_next.out[tone_pkg::LINE_SIX] =
                    tone_reg && port_a_output_data_reg[tone_pkg::LINE_SIX];
                // Line six as input leaves line seven as a plain data output
                if (dir_line_six) begin
                    drive_next.out[tone_pkg::LINE_SEVEN] =
                        port_a_output_data_reg[tone_pkg::LINE_SEVEN];
                end else begin
                    drive_next.out[tone_pkg::LINE_SEVEN] =
                        !tone_reg && port_a_output_data_reg[tone_pkg::LINE_SIX];
                end
            end
            default: begin
                drive_next.out = port_a_output_data_reg;
            end
        endcase
        if (dir_line_six) begin
            drive_next.oe_n[tone_pkg::LINE_SIX] = 1'b1;
        end
        if (dir_line_seven) begin
            drive_next.oe_n[tone_pkg::LINE_SEVEN] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            drive_reg.out  <= tone_pkg::PORT_DATA_RESET;
            drive_reg.oe_n <= tone_pkg::PORT_DIR_RESET;
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign PORT_A_OUT       = drive_reg.out;
    assign PORT_A_OE_N      = drive_reg.oe_n;
    assign PORT_A_PIN_STATE = pin_state_reg;
    assign S_AXI_AWREADY    = awready_reg;
    assign S_AXI_WREADY     = wready_reg;
    assign S_AXI_BVALID     = bvalid_reg;
    assign S_AXI_BRESP      = bresp_reg;
    assign S_AXI_ARREADY    = arready_reg;
    assign S_AXI_RVALID     = rvalid_reg;
    assign S_AXI_RDATA      = rdata_reg;
    assign S_AXI_RRESP      = rresp_reg;

endmodule

// >>> rtl/tone_pkg.sv
// Package: register map, field layout, reset values and structs for the buzzer tone generator
package tone_pkg;
    localparam logic [3:0]  ADDR_BUZZER_CONTROL  = 4'h0;
    localparam logic [3:0]  ADDR_TIME_BASE_CTRL  = 4'h4;
    localparam logic [3:0]  ADDR_PORT_A_DIR      = 4'h8;
    localparam logic [3:0]  ADDR_PORT_A_DATA     = 4'hc;

    localparam logic [7:0]  BUZZER_CONTROL_RESET = 8'h00;
    localparam logic [7:0]  TIME_BASE_RESET      = 8'h00;
    localparam logic [7:0]  PORT_DIR_RESET       = 8'hff;
    localparam logic [7:0]  PORT_DATA_RESET      = 8'h00;

    localparam int          FREQ_LSB             = 0;
    localparam int          FREQ_MSB             = 2;
    localparam int          FUNC_LSB             = 3;
    localparam int          FUNC_MSB             = 4;
    localparam logic [7:0]  BUZZER_CONTROL_MASK  = 8'h1f;
    localparam int          TB_ENABLE_BIT        = 7;
    localparam int          TB_SOURCE_BIT        = 6;
    localparam logic [7:0]  TIME_BASE_MASK       = 8'hc0;
    localparam int          LINE_SIX             = 6;
    localparam int          LINE_SEVEN           = 7;

    localparam logic [1:0]  FUNC_ALL_IO          = 2'h0;
    localparam logic [1:0]  FUNC_SINGLE          = 2'h1;
    localparam logic [1:0]  FUNC_RESERVED        = 2'h2;
    localparam logic [1:0]  FUNC_PAIR            = 2'h3;

    localparam logic [1:0]  SYS_DIVIDE_MAX       = 2'h3;
    localparam int          DIVIDER_WIDTH        = 9;
    localparam logic [3:0]  MIN_POWER            = 4'h2;
    localparam logic [1:0]  RESP_OKAY            = 2'h0;
    localparam logic [1:0]  RESP_SLVERR          = 2'h2;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } pin_drive_t;
endpackage

// >>> verification/piezo_load.sv
// Far-side pin model: buzzer load and optional outside driver
`timescale 1ns/10ps
module piezo_load (
    input  wire logic       clk,
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe_n,
    input  wire logic [7:0] ext,
    input  wire logic       ext_en,
    output logic      [7:0] pin
);
    logic [7:0] pat = 8'h55;
    // Floating lines show a changing pattern, never a held level
    always @(posedge clk) pat <= ~pat;
    always_comb begin
        for (int i = 0; i < 8; i++) pin[i] = !oe_n[i] ? out[i] : (ext_en ? ext[i] : pat[i]);
    end
endmodule

// >>> verification/tb.sv
// Self-checking testbench for the buzzer tone generator
`timescale 1ns/10ps
module tb;
    logic        CLK, RST, awv, wv, bv, br, arv, arr, rv, rr, awr, wrr, ext_en;
    logic        osc = 1'b0;
    logic [2:0]  oc = 3'h0;
    logic [3:0]  awa, ara, strb;
    logic [31:0] wd, rdat;
    logic [1:0]  bresp, rresp;
    logic [7:0]  po, poe, pst, pins, ext;
    logic [33:0] qr[$];
    logic [1:0]  qb[$];
    int          err_total = 0, n_checks = 0, seed, r, c;
    localparam logic [1:0] OK = tone_pkg::RESP_OKAY;
    localparam logic [1:0] SE = tone_pkg::RESP_SLVERR;
    buzzer_frequency_output u_dut (.CLK(CLK), .RST(RST), .LOW_SPEED_INTERNAL_OSC(osc), .PORT_A_IN(pins),
        .PORT_A_OUT(po), .PORT_A_OE_N(poe), .PORT_A_PIN_STATE(pst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    piezo_load u_load (.clk(CLK), .out(po), .oe_n(poe), .ext(ext), .ext_en(ext_en), .pin(pins));
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // Slow oscillator: period of ten clocks
    always @(posedge CLK) begin
        oc <= (oc == 3'h4) ? 3'h0 : oc + 3'h1;
        if (oc == 3'h4) osc <= !osc;
    end
    task automatic cmp_b(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t write resp %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_r(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_p(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t pin state %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
        bit ah, wh, bh = 0;
        qb.push_back(e);
        @(posedge CLK);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!bh) begin
            @(negedge CLK);
            ah = awv && awr;
            wh = wv && wrr;
            bh = bv && br;
            @(posedge CLK);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
            if (bh) br <= 1'b0;
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        bit ah, rh = 0;
        qr.push_back({d, e});
        @(posedge CLK);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (!rh) begin
            @(negedge CLK);
            ah = arv && arr;
            rh = rv && rr;
            @(posedge CLK);
            if (ah) arv <= 1'b0;
            if (rh) rr <= 1'b0;
        end
    endtask
    always @(negedge CLK) begin
        if (bv && br) cmp_b(bresp, qb.pop_front());
        if (rv && rr) cmp_r({rdat, rresp}, qr.pop_front());
    end
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge CLK);
        err_total++;
        end_of_test;
    end
    initial begin
        seed = 32'h5d99;
        RST = 1'b1;
        {awv, wv, br, arv, rr, ext_en, awa, ara, wd} = '0;
        strb = 4'h1;
        ext = 8'($random(seed));
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        ext_en <= 1'b1;
        rd(4'h0, 32'h0, OK);
        rd(4'h4, 32'h0, OK);
        rd(4'h8, 32'hff, OK);
        r = $random(seed);
        wr(4'h0, r[7:0], OK);
        rd(4'h0, {27'h0, r[4:0]}, OK);
        strb <= 4'h0;
        wr(4'h0, 8'h00, OK);
        strb <= 4'h1;
        rd(4'h0, {27'h0, r[4:0]}, OK);
        wr(4'h2, 8'h00, SE);
        rd(4'h2, 32'h0, SE);
        wr(4'h8, 8'h3f, OK);
        wr(4'hc, 8'h40, OK);
        wr(4'h4, 8'hc0, OK);
        for (c = 0; c < 8; c++) begin
            wr(4'h0, {3'h0, tone_pkg::FUNC_PAIR, c[2:0]}, OK);
            repeat (20 + (24 << c)) @(posedge CLK);
        end
        wr(4'hc, 8'hc0, OK);
        wr(4'h0, {3'h0, tone_pkg::FUNC_SINGLE, 3'h1}, OK);
        repeat (100) @(posedge CLK);
        wr(4'h0, {3'h0, tone_pkg::FUNC_PAIR, 3'h0}, OK);
        repeat (60) @(posedge CLK);
        wr(4'hc, 8'h80, OK);
        repeat (40) @(posedge CLK);
        for (c = 0; c < 2; c++) begin
            r = $random(seed);
            wr(4'hc, r[7:0], OK);
            wr(4'h0, {3'h0, c ? tone_pkg::FUNC_RESERVED : tone_pkg::FUNC_ALL_IO, 3'h0}, OK);
            repeat (20) @(posedge CLK);
        end
        wr(4'hc, 8'h40, OK);
        wr(4'h0, {3'h0, tone_pkg::FUNC_SINGLE, 3'h0}, OK);
        wr(4'h4, 8'h00, OK);
        repeat (40) @(posedge CLK);
        wr(4'h0, {3'h0, tone_pkg::FUNC_PAIR, 3'h0}, OK);
        wr(4'h8, 8'h40, OK);
        repeat (10) @(posedge CLK);
        rd(4'hc, {24'h0, 1'b0, ext[6], 6'h00}, OK);
        @(negedge CLK);
        cmp_p(pst, {1'b0, ext[6], 6'h00});
        wr(4'h8, 8'h00, OK);
        wr(4'h0, {3'h0, tone_pkg::FUNC_SINGLE, 3'h1}, OK);
        wr(4'h4, 8'h80, OK);
        repeat (400) @(posedge CLK);
        end_of_test;
    end
endmodule
bind buzzer_frequency_output tone_checker u_chk (
    .CLK(CLK),
    .RST(RST),
    .LOW_SPEED_INTERNAL_OSC(LOW_SPEED_INTERNAL_OSC),
    .PORT_A_OUT(PORT_A_OUT),
    .PORT_A_OE_N(PORT_A_OE_N),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID)
);

// >>> verification/tone_checker.sv
// Port assertions for the buzzer tone generator
`timescale 1ns/10ps
module tone_checker (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        LOW_SPEED_INTERNAL_OSC,
    input wire logic [7:0]  PORT_A_OUT,
    input wire logic [7:0]  PORT_A_OE_N,
    input wire logic [3:0]  S_AXI_AWADDR,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0]  S_AXI_WSTRB,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID
);
    logic [3:0]  aq, age;
    logic [7:0]  wq, ctl, tbc, dir, dat;
    logic        sq, bvd, od, o6d, seen, ap, un, ok, on, tg;
    logic [11:0] hp, hpx;
    logic [1:0]  fn;
    // Shadow registers follow each OKAY write with byte 0 strobe set
    assign fn  = ctl[4:3];
    assign ap  = S_AXI_BVALID && !bvd && S_AXI_BRESP == tone_pkg::RESP_OKAY && sq;
    assign un  = tbc[6] || (LOW_SPEED_INTERNAL_OSC && !od);
    assign on  = fn == tone_pkg::FUNC_SINGLE || fn == tone_pkg::FUNC_PAIR;
    assign ok  = on && age == 4'hf && tbc[7] && dat[6] && !dir[6];
    assign tg  = PORT_A_OUT[6] != o6d;
    assign hpx = (tbc[6] ? 12'h004 : 12'h001) << ({1'b0, ctl[2:0]} + 4'h1);
    always_ff @(posedge CLK) begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) aq <= S_AXI_AWADDR;
        if (S_AXI_WVALID && S_AXI_WREADY) wq <= S_AXI_WDATA[7:0];
        if (S_AXI_WVALID && S_AXI_WREADY) sq <= S_AXI_WSTRB[0];
    end
    always_ff @(posedge CLK) begin
        bvd  <= !RST && S_AXI_BVALID;
        od   <= LOW_SPEED_INTERNAL_OSC;
        o6d  <= PORT_A_OUT[6];
        hp   <= tg ? {11'h0, un} : hp + {11'h0, un};
        seen <= !(RST || ap) && (seen || (ok && tg));
        age  <= (RST || ap) ? 4'h0 : age + {3'h0, age != 4'hf};
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctl <= 8'h00;
            tbc <= 8'h00;
            dir <= 8'hff;
            dat <= 8'h00;
        end else if (ap) begin
            case (aq)
                tone_pkg::ADDR_BUZZER_CONTROL: ctl <= wq;
                tone_pkg::ADDR_TIME_BASE_CTRL: tbc <= wq;
                tone_pkg::ADDR_PORT_A_DIR:     dir <= wq;
                tone_pkg::ADDR_PORT_A_DATA:    dat <= wq;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    reset_pins_a: assert property (disable iff (1'b0) RST |=> PORT_A_OE_N == 8'hff && PORT_A_OUT == 8'h00)
        else $error("pins not idle after reset");
    dir_drive_a: assert property (age != 4'h0 |-> PORT_A_OE_N == dir)
        else $error("output enable differs from direction");
    pair_inverse_a: assert property (fn == tone_pkg::FUNC_PAIR && age > 4'h3 && dat[6] && !dir[6] |-> PORT_A_OUT[7] == !PORT_A_OUT[6])
        else $error("pair outputs not complementary");
    pair_gate_a: assert property (fn == tone_pkg::FUNC_PAIR && age > 4'h3 && !dat[6] && !dir[6] |-> PORT_A_OUT[7:6] == 2'h0)
        else $error("pair outputs not held low");
    pair_input_a: assert property (fn == tone_pkg::FUNC_PAIR && age > 4'h3 && dir[6] |-> PORT_A_OUT[7] == dat[7])
        else $error("line seven not plain data with line six input");
    single_line_a: assert property (fn == tone_pkg::FUNC_SINGLE && age > 4'h3 |-> PORT_A_OUT[7] == dat[7] && (dat[6] || !PORT_A_OUT[6]))
        else $error("single mode pins wrong");
    plain_io_a: assert property (!on && age > 4'h3 |-> PORT_A_OUT[7:6] == dat[7:6])
        else $error("plain port data not driven");
    tone_stop_a: assert property (on && !tbc[7] && age > 4'h3 |-> !PORT_A_OUT[6])
        else $error("tone runs without time base");
    half_period_a: assert property (ok && seen && tg |-> hp == hpx)
        else $error("tone half period wrong");
endmodule
